/* File: lock_pkg.sv */
package lock_pkg;
    localparam logic [7:0] OP_UNLOCK_ONE = 8'h39;
    localparam logic [7:0] OP_UNLOCK_ONE_WIDE = 8'he2;
    localparam logic [7:0] OP_LOCK_ONE = 8'h36;
    localparam logic [7:0] OP_LOCK_ONE_WIDE = 8'he1;
    localparam logic [7:0] OP_LOCK_ALL = 8'h7e;
    localparam logic [7:0] OP_UNLOCK_ALL = 8'h98;
    localparam logic [7:0] OP_SET_REGION = 8'hfb;
    localparam logic [7:0] OP_SET_REGION_WIDE = 8'he3;
    localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
    localparam int OP_BITS = 8;
    localparam int ADDR_BITS_SHORT = 24;
    localparam int ADDR_BITS_LONG = 32;
    localparam int BLOCKS_DEF = 16;
    localparam int BLOCK_SHIFT_DEF = 16;
    localparam int BUSY_NS = 2000;
    localparam int CLK_NS = 40;
    localparam int BUSY_CYCLES = (BUSY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] BITCNT_RESET = 7'h00;
    localparam logic [31:0] REGION_RESET = 32'hffffffff;
    typedef enum {ST_IDLE, ST_BUSY} seq_state_type;
    typedef enum {OPK_NONE, OPK_UNLOCK1, OPK_LOCK1, OPK_LOCKALL, OPK_UNLOCKALL,
        OPK_REGION, OPK_WALLOW} op_kind_type;
endpackage

/* File: frame_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
    logic sclk_rise;
    logic frame_start;
    logic frame_end;
    logic [3:0] io;
    modport source (output sclk_rise, output frame_start, output frame_end,
        output io);
    modport sink (input sclk_rise, input frame_start, input frame_end,
        input io);
endinterface
`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Raw pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    // Edge events
    frame_if.source ev
);
    logic [5:0] s1_q, s1_d, s2_q, s2_d;
    logic sclk_old_q, sclk_old_d, cs_old_q, cs_old_d;

    always_comb
    begin
        s1_d = {sclk, cs_n, io_in};
        s2_d = s1_q;
        sclk_old_d = s2_q[5];
        cs_old_d = s2_q[4];
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            s1_q <= 6'h10;
            s2_q <= 6'h10;
            sclk_old_q <= 1'b0;
            cs_old_q <= 1'b1;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            sclk_old_q <= sclk_old_d;
            cs_old_q <= cs_old_d;
        end
    end

    assign ev.sclk_rise = s2_q[5] & ~sclk_old_q & ~s2_q[4];
    assign ev.frame_start = cs_old_q & ~s2_q[4];
    assign ev.frame_end = ~cs_old_q & s2_q[4];
    assign ev.io = s2_q[3:0];
endmodule // pin_sync
`default_nettype wire

/* File: block_lock_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module block_lock_ctrl
    import lock_pkg::*;
#(
    parameter int BLOCKS = BLOCKS_DEF,
    parameter int BLOCK_SHIFT = BLOCK_SHIFT_DEF
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    // Configuration
    input wire logic four_wire_command_mode,
    input wire logic addr_len_long,
    input wire logic protection_scheme_select,
    input wire logic lockdown_bit,
    input wire logic power_lockdown_bit,
    input wire logic password_bit,
    input wire logic suspend_active,
    input wire logic region_fail,
    input wire logic region_fail_is_erase,
    // Status
    output logic op_in_progress_flag,
    output logic op_in_progress_cfg,
    output logic write_allow_latch,
    output logic program_error,
    output logic erase_error,
    output logic [BLOCKS-1:0] block_lock_bit,
    output logic [31:0] pointer_region_reg
);
    frame_if ev ();

    pin_sync u_sync
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .sclk(sclk),
        .cs_n(cs_n),
        .io_in(io_in),
        .ev(ev)
    );

    // ------------------------------------------------------------
    // Command shifter
    // ------------------------------------------------------------
    logic [39:0] shift_q, shift_d;
    logic [6:0] bits_q, bits_d;
    logic [7:0] opcode;
    logic [31:0] addr_word;
    logic wide_op;
    logic wide_code;
    logic [6:0] need_bits;

    always_comb
    begin
        shift_d = shift_q;
        bits_d = bits_q;
        if (ev.frame_start)
        begin
            shift_d = '0;
            bits_d = BITCNT_RESET;
        end
        // Overlong frames stop counting at 48 bits so they never match
        else if (ev.sclk_rise && bits_q < 7'd48)
        begin
            if (four_wire_command_mode)
            begin
                shift_d = {shift_q[35:0], ev.io};
                bits_d = bits_q + 7'd4;
            end
            else
            begin
                shift_d = {shift_q[38:0], ev.io[0]};
                bits_d = bits_q + 7'd1;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            shift_q <= '0;
            bits_q <= BITCNT_RESET;
        end
        else
        begin
            shift_q <= shift_d;
            bits_q <= bits_d;
        end
    end

    // ------------------------------------------------------------
    // Decode at frame end
    // ------------------------------------------------------------
    op_kind_type kind;
    logic accept;

    assign wide_code = shift_q[39:32] == OP_UNLOCK_ONE_WIDE ||
        shift_q[39:32] == OP_LOCK_ONE_WIDE ||
        shift_q[39:32] == OP_SET_REGION_WIDE;
    assign wide_op = addr_len_long || wide_code;
    assign need_bits = wide_op ? 7'(OP_BITS + ADDR_BITS_LONG) :
        7'(OP_BITS + ADDR_BITS_SHORT);
    assign opcode = wide_op ? shift_q[39:32] : shift_q[31:24];
    assign addr_word = wide_op ? shift_q[31:0] : {8'h00, shift_q[23:0]};

    always_comb
    begin
        kind = OPK_NONE;
        accept = 1'b0;
        if (bits_q == 7'(OP_BITS))
        begin
            case (shift_q[7:0])
                OP_LOCK_ALL: kind = OPK_LOCKALL;
                OP_UNLOCK_ALL: kind = OPK_UNLOCKALL;
                OP_WRITE_ALLOW: kind = OPK_WALLOW;
                default: kind = OPK_NONE;
            endcase
        end
        else if (bits_q == need_bits)
        begin
            // wide opcodes need a 32-bit address
            case (opcode)
                OP_UNLOCK_ONE: kind = OPK_UNLOCK1;
                OP_UNLOCK_ONE_WIDE: kind = wide_op ? OPK_UNLOCK1 : OPK_NONE;
                OP_LOCK_ONE: kind = OPK_LOCK1;
                OP_LOCK_ONE_WIDE: kind = wide_op ? OPK_LOCK1 : OPK_NONE;
                OP_SET_REGION: kind = OPK_REGION;
                OP_SET_REGION_WIDE: kind = wide_op ? OPK_REGION : OPK_NONE;
                default: kind = OPK_NONE;
            endcase
        end
        case (kind)
            OPK_UNLOCK1, OPK_LOCK1, OPK_LOCKALL, OPK_UNLOCKALL:
                accept = protection_scheme_select;
            OPK_REGION:
                accept = write_allow_latch && !suspend_active &&
                    lockdown_bit && power_lockdown_bit &&
                    !(!password_bit && !lockdown_bit);
            OPK_WALLOW: accept = 1'b1;
            default: accept = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Self-timed operation
    // ------------------------------------------------------------
    seq_state_type state_q, state_d;
    op_kind_type pend_q, pend_d;
    logic [31:0] paddr_q, paddr_d;
    logic [15:0] cnt_q, cnt_d;
    logic [BLOCKS-1:0] lock_q, lock_d;
    logic [31:0] region_q, region_d;
    logic wel_q, wel_d, perr_q, perr_d, eerr_q, eerr_d;
    logic [31:0] blk_idx;

    assign blk_idx = paddr_q >> BLOCK_SHIFT;

    always_comb
    begin
        state_d = state_q;
        pend_d = pend_q;
        paddr_d = paddr_q;
        cnt_d = cnt_q;
        lock_d = lock_q;
        region_d = region_q;
        wel_d = wel_q;
        perr_d = perr_q;
        eerr_d = eerr_q;
        case (state_q)
            ST_IDLE:
            begin
                if (ev.frame_end && accept)
                begin
                    if (kind == OPK_WALLOW)
                        wel_d = 1'b1;
                    else
                    begin
                        state_d = ST_BUSY;
                        pend_d = kind;
                        paddr_d = addr_word;
                        cnt_d = 16'(BUSY_CYCLES);
                    end
                end
            end
            ST_BUSY:
            begin
                if (cnt_q > 16'd1)
                    cnt_d = cnt_q - 16'd1;
                else
                begin
                    state_d = ST_IDLE;
                    case (pend_q)
                        OPK_UNLOCK1:
                            if (blk_idx < BLOCKS)
                                lock_d[blk_idx] = 1'b1;
                        OPK_LOCK1:
                            if (blk_idx < BLOCKS)
                                lock_d[blk_idx] = 1'b0;
                        OPK_LOCKALL: lock_d = '0;
                        OPK_UNLOCKALL: lock_d = '1;
                        OPK_REGION:
                        begin
                            wel_d = 1'b0;
                            if (region_fail)
                            begin
                                perr_d = perr_q | ~region_fail_is_erase;
                                eerr_d = eerr_q | region_fail_is_erase;
                            end
                            else
                                region_d = paddr_q;
                        end
                        default: lock_d = lock_q;
                    endcase
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            pend_q <= OPK_NONE;
            paddr_q <= '0;
            cnt_q <= '0;
            lock_q <= '0;
            region_q <= REGION_RESET;
            wel_q <= 1'b0;
            perr_q <= 1'b0;
            eerr_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            pend_q <= pend_d;
            paddr_q <= paddr_d;
            cnt_q <= cnt_d;
            lock_q <= lock_d;
            region_q <= region_d;
            wel_q <= wel_d;
            perr_q <= perr_d;
            eerr_q <= eerr_d;
        end
    end

    assign op_in_progress_flag = (state_q == ST_BUSY);
    assign op_in_progress_cfg = (state_q == ST_BUSY);
    assign write_allow_latch = wel_q;
    assign program_error = perr_q;
    assign erase_error = eerr_q;
    assign block_lock_bit = lock_q;
    assign pointer_region_reg = region_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_busy_start: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_IDLE && ev.frame_end && accept && kind != OPK_WALLOW
        |=> op_in_progress_flag [*2])
        else $error("busy not raised on accepted frame end");
    chk_lockall_done: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_BUSY && cnt_q == 16'd1 && pend_q == OPK_LOCKALL
        |=> block_lock_bit == '0 && !op_in_progress_flag)
        else $error("lock all did not clear bits");
    chk_unlockall: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_BUSY && cnt_q == 16'd1 && pend_q == OPK_UNLOCKALL
        |=> block_lock_bit == '1)
        else $error("unlock all did not set bits");
    chk_scheme_gate: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_IDLE && ev.frame_end && !protection_scheme_select &&
        kind != OPK_REGION && kind != OPK_WALLOW
        |=> !op_in_progress_flag)
        else $error("lock command ran without scheme select");
    chk_region_wel: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_IDLE && ev.frame_end && kind == OPK_REGION &&
        !write_allow_latch |=> !op_in_progress_flag)
        else $error("region ran without write latch");
    chk_region_susp: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_IDLE && ev.frame_end && kind == OPK_REGION &&
        suspend_active
        |=> $stable(write_allow_latch) && !op_in_progress_flag)
        else $error("region ran during suspend");
    chk_region_end: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_BUSY && cnt_q == 16'd1 && pend_q == OPK_REGION
        |=> !write_allow_latch && !op_in_progress_flag)
        else $error("region end did not clear latch");
    chk_region_err: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_BUSY && cnt_q == 16'd1 && pend_q == OPK_REGION &&
        region_fail |=> program_error || erase_error)
        else $error("region failure not flagged");
    chk_cnt_down: assert property (
        @(posedge mclk) disable iff (!reset_n)
        state_q == ST_BUSY && cnt_q > 16'd1
        |=> cnt_q == $past(cnt_q) - 16'd1)
        else $error("busy counter stalled");
endmodule // block_lock_ctrl
`default_nettype wire

/* File: spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model
(
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io
);
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io = 4'h0;
    end

    task automatic send(input logic [39:0] bits, input int n,
        input logic quad);
        int i;
        cs_n = 1'b0;
        i = 0;
        while (i < n)
        begin
            if (quad)
                io = bits[39-i -: 4];
            else
                io = {~io[3:1], bits[39-i]};
            #160 sclk = 1'b1;
            #160 sclk = 1'b0;
            i = i + (quad ? 4 : 1);
        end
        // select rises after the last bit
        #160 cs_n = 1'b1;
        io = ~io;
        #320;
    endtask
endmodule // spi_host_model
`default_nettype wire

/* File: block_lock_pointer_region_cmds_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module block_lock_pointer_region_cmds_bench;
    import lock_pkg::*;
    typedef struct packed {
        logic [7:0] op;
        logic [31:0] addr;
        logic [5:0] nbits;
        logic quad;
        logic alen;
        logic [15:0] lock;
    } row_type;
    logic mclk, reset_n, sclk, cs_n;
    logic [3:0] io_in;
    logic qmode, alen, pss, lockdown, power_lock, password, suspend;
    logic rfail, rfail_erase, busy, busy_cfg, wal, perr, eerr;
    logic [15:0] lock;
    logic [31:0] region;
    int blen = 0;
    int last_len = 0;
    int rises = 0;
    int cfg_bad = 0;
    int errors, tests_run;
    row_type rows [7];

    spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n), .io(io_in));
    block_lock_ctrl #(.BLOCKS(16), .BLOCK_SHIFT(16)) i_block_lock_ctrl (
        .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
        .io_in(io_in), .four_wire_command_mode(qmode),
        .addr_len_long(alen), .protection_scheme_select(pss),
        .lockdown_bit(lockdown), .power_lockdown_bit(power_lock),
        .password_bit(password), .suspend_active(suspend),
        .region_fail(rfail), .region_fail_is_erase(rfail_erase),
        .op_in_progress_flag(busy), .op_in_progress_cfg(busy_cfg),
        .write_allow_latch(wal), .program_error(perr), .erase_error(eerr),
        .block_lock_bit(lock), .pointer_region_reg(region));

    // ----------------------------------------
    // Clock and busy length monitor
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        if (reset_n === 1'b1 && busy_cfg !== busy)
            cfg_bad <= cfg_bad + 1;
        if (busy === 1'b1)
        begin
            if (blen == 0)
                rises <= rises + 1;
            blen <= blen + 1;
        end
        else if (blen != 0)
        begin
            last_len <= blen;
            blen <= 0;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic run(input logic [7:0] op, input logic [31:0] addr,
        input int nbits, input logic quad, input logic exp_busy);
        int k;
        int r0;
        @(posedge mclk);
        #1;
        r0 = rises;
        qmode = quad;
        i_spi_host_model.send({op, addr << (40 - nbits)}, nbits, quad);
        k = 0;
        while (busy !== 1'b0 && k < 200)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        @(posedge mclk);
        #1;
        if (k == 200)
        begin
            errors++;
            $display("CHECK FAILED busy wait expected low seen high");
            stop_test();
        end
        else
        begin
            check("busy seen", rises - r0, {31'h0, exp_busy});
            if (exp_busy)
                check("busy length", last_len, BUSY_CYCLES);
        end
    endtask

    task automatic region_try(input logic exp_busy);
        run(OP_SET_REGION, 32'h00123400, 32, 1'b0, exp_busy);
        check("region", region, exp_busy ? 32'h00123400 : 32'hffffffff);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rows = '{
            '{OP_UNLOCK_ALL, 32'h0, 6'h08, 1'b0, 1'b0, 16'hffff},
            '{OP_LOCK_ALL, 32'h0, 6'h08, 1'b1, 1'b0, 16'h0000},
            '{OP_UNLOCK_ONE, 32'h00030000, 6'h20, 1'b0, 1'b0, 16'h0008},
            '{OP_UNLOCK_ONE_WIDE, 32'h00050000, 6'h28, 1'b1, 1'b0, 16'h0028},
            '{OP_UNLOCK_ONE, 32'h00070000, 6'h28, 1'b0, 1'b1, 16'h00a8},
            '{OP_LOCK_ONE, 32'h00030000, 6'h20, 1'b1, 1'b0, 16'h00a0},
            '{OP_LOCK_ONE_WIDE, 32'h00050000, 6'h28, 1'b0, 1'b0, 16'h0080}};
        {qmode, alen, suspend, rfail, rfail_erase, reset_n} = 6'h00;
        {pss, lockdown, power_lock, password} = 4'hf;
        {errors, tests_run} = '0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check("reset lock", lock, 16'h0000);
        check("reset region", region, 32'hffffffff);
        check("reset flags", {busy, wal, perr, eerr}, 4'h0);
        $display("test reset done");
        for (int r = 0; r < 7; r++)
        begin
            alen = rows[r].alen;
            run(rows[r].op, rows[r].addr, rows[r].nbits, rows[r].quad, 1'b1);
            check("lock bits", lock, rows[r].lock);
            $display("test row %0d done", r);
        end
        alen = 1'b0;
        run(OP_LOCK_ALL, 32'h1, 9, 1'b0, 1'b0);
        check("long lock all", lock, 16'h0080);
        pss = 1'b0;
        run(OP_UNLOCK_ALL, 32'h0, 8, 1'b0, 1'b0);
        check("scheme off", lock, 16'h0080);
        pss = 1'b1;
        $display("test refused lock done");
        region_try(1'b0);
        check("latch idle", wal, 1'b0);
        run(OP_WRITE_ALLOW, 32'h0, 8, 1'b0, 1'b0);
        check("latch set", wal, 1'b1);
        suspend = 1'b1;
        region_try(1'b0);
        suspend = 1'b0;
        lockdown = 1'b0;
        region_try(1'b0);
        lockdown = 1'b1;
        power_lock = 1'b0;
        region_try(1'b0);
        power_lock = 1'b1;
        run(OP_SET_REGION, 32'h00123400, 28, 1'b0, 1'b0);
        check("latch kept", wal, 1'b1);
        region_try(1'b1);
        check("latch cleared", wal, 1'b0);
        $display("test region done");
        run(OP_WRITE_ALLOW, 32'h0, 8, 1'b0, 1'b0);
        {rfail, rfail_erase} = 2'h3;
        run(OP_SET_REGION_WIDE, 32'h00abc000, 40, 1'b1, 1'b1);
        check("fail flags", {perr, eerr}, 2'h1);
        check("fail region", region, 32'h00123400);
        rfail_erase = 1'b0;
        run(OP_WRITE_ALLOW, 32'h0, 8, 1'b0, 1'b0);
        run(OP_SET_REGION, 32'h00456700, 32, 1'b0, 1'b1);
        check("program fail", {perr, eerr}, 2'h3);
        check("program fail region", region, 32'h00123400);
        check("fail latch", wal, 1'b0);
        rfail = 1'b0;
        $display("test region failure done");
        check("progress cfg", cfg_bad, 0);
        stop_test();
    end
endmodule // block_lock_pointer_region_cmds_bench
`default_nettype wire
